// *** src/fspc_pkg.sv ***
// Summary of operation
// [R1] table read copies addressed byte into latch
// [R2] table read may update pointer automatically
// [R3] pointer bit zero selects word high/low byte
// [R4] erase clears exactly one 64-byte block
// [R5] erase uses pointer bits 21:6 only
// [R6] software sets code, permit, erase bits first
// [R7] software clears settings space select for erase
// [R8] start accepted only after 55h then aah
// [R9] start with erase selected begins row erase
// [R10] long write stalls cpu, ends by timer
// [R11] programming unit is one 8-byte block
// [R12] eight byte-wide holding registers feed programming
// [R13] table writes only fill holding registers
// [R14] software places a nop after start
// [R15] pointer modes: none, post-inc, post-dec, pre-inc
// [R16] pointer 2:0 picks register, 21:3 block
// [R17] start settable only, cleared by hardware
// [R18] completion sets flag until software clears
// [R19] start ignored without permit or fresh unlock
// [R20] no erase selected: program eight holding bytes
package fspc_pkg;
    localparam int unsigned PTR_W = 22;
    localparam int unsigned MOD_W = 21;
    localparam int unsigned WORD_AW = 21;
    localparam int unsigned ERASE_LSB = 6;
    localparam int unsigned BLOCK_LSB = 3;
    localparam int unsigned HOLD_N = 8;
    localparam int unsigned ROW_WORDS = 32;
    localparam int unsigned BLK_WORDS = 4;
    localparam logic [7:0] UNLOCK_A = 8'h55;
    localparam logic [7:0] UNLOCK_B = 8'haa;
    localparam logic [7:0] HOLD_RST = 8'hff;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned LONG_WRITE_US = 2000;
    localparam int unsigned LONG_WRITE_CYC = LONG_WRITE_US * CLK_MHZ;

    typedef enum logic [1:0] {
        FSPC_PTR_KEEP,
        FSPC_PTR_POST_INC,
        FSPC_PTR_POST_DEC,
        FSPC_PTR_PRE_INC
    } fspc_ptr_mode_t;

    typedef struct packed {
        logic fetch;
        logic load;
        fspc_ptr_mode_t mode;
    } fspc_table_op_t;

    typedef struct packed {
        logic code_space_select;
        logic settings_space_select;
        logic row_erase;
        logic cycle_permit;
    } fspc_ctrl_t;

    typedef struct packed {
        logic we;
        logic [WORD_AW-1:0] addr;
        logic [15:0] data;
    } fspc_wport_t;
endpackage : fspc_pkg

// *** src/fspc_long_timer.sv ***
`timescale 1ns/1ps
module fspc_long_timer #(
    parameter int unsigned CYCLES = fspc_pkg::LONG_WRITE_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    output logic busy,
    output logic done
);
    logic [31:0] cnt_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_q <= 32'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                cnt_q <= CYCLES - 1;
            end else if (busy) begin
                if (cnt_q == 32'h0) begin
                    busy <= 1'b0;
                    done <= 1'b1; // R10
                end else begin
                    cnt_q <= cnt_q - 32'h1;
                end
            end
        end
    end
endmodule : fspc_long_timer

// *** src/fspc_ctrl.sv ***
`timescale 1ns/1ps
module fspc_ctrl #(
    parameter int unsigned LONG_WRITE_CYCLES = fspc_pkg::LONG_WRITE_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    // table instruction strobe from core
    input wire fspc_pkg::fspc_table_op_t table_op,
    input wire logic [7:0] latch_wdata,
    input wire logic latch_we,
    input wire logic [fspc_pkg::PTR_W-1:0] ptr_wdata,
    input wire logic ptr_we,
    // control register bits
    input wire fspc_pkg::fspc_ctrl_t ctrl_wdata,
    input wire logic ctrl_we,
    input wire logic start_set,
    input wire logic [7:0] unlock_wdata,
    input wire logic unlock_we,
    input wire logic done_flag_clr,
    // program memory read data for the word at mem_raddr
    input wire logic [15:0] mem_rdata,
    output logic [fspc_pkg::WORD_AW-1:0] mem_raddr,
    output fspc_pkg::fspc_wport_t mem_wport,
    output logic [fspc_pkg::PTR_W-1:0] table_pointer,
    output logic [7:0] table_latch,
    output fspc_pkg::fspc_ctrl_t nvm_control,
    output logic start_busy,
    output logic cpu_stall,
    output logic nvm_cycle_done_flag
);
    typedef enum logic [1:0] {
        FSPC_IDLE,
        FSPC_ARRAY,
        FSPC_WAIT
    } fspc_state_t;

    typedef enum logic [1:0] {
        FSPC_UNL_NONE,
        FSPC_UNL_HALF,
        FSPC_UNL_FULL
    } fspc_unl_t;

    fspc_state_t state_q;
    fspc_unl_t unl_q;
    logic [fspc_pkg::PTR_W-1:0] ptr_q;
    logic [fspc_pkg::PTR_W-1:0] ptr_eff;
    logic [fspc_pkg::PTR_W-1:0] ptr_next;
    logic [7:0] latch_q;
    logic [7:0] hold_q [fspc_pkg::HOLD_N];
    fspc_pkg::fspc_ctrl_t ctrl_q;
    logic start_q;
    logic erase_q;
    logic [4:0] word_idx_q;
    logic [fspc_pkg::WORD_AW-1:0] base_q;
    fspc_pkg::fspc_wport_t wport_q;
    logic done_flag_q;
    logic stall_q;
    logic timer_start;
    logic timer_busy;
    logic timer_done;
    logic accept;
    logic fetch_pend_q;
    logic fetch_lo_q;
    logic [fspc_pkg::MOD_W-1:0] low_mod;

    assign accept = start_set && !start_q && ctrl_q.cycle_permit && (unl_q == FSPC_UNL_FULL); // R8 R19

    // pointer: pre-increment forms the effective address, others act afterwards
    always_comb begin
        low_mod = ptr_q[fspc_pkg::MOD_W-1:0];
        ptr_eff = ptr_q;
        if (table_op.mode == fspc_pkg::FSPC_PTR_PRE_INC) begin
            low_mod = ptr_q[fspc_pkg::MOD_W-1:0] + 21'h1;
            ptr_eff = {ptr_q[fspc_pkg::PTR_W-1], low_mod}; // R15
        end
        ptr_next = ptr_eff;
        unique case (table_op.mode)
            fspc_pkg::FSPC_PTR_KEEP: ptr_next = ptr_q;
            fspc_pkg::FSPC_PTR_POST_INC: ptr_next = {ptr_q[fspc_pkg::PTR_W-1],
                ptr_q[fspc_pkg::MOD_W-1:0] + 21'h1}; // R15
            fspc_pkg::FSPC_PTR_POST_DEC: ptr_next = {ptr_q[fspc_pkg::PTR_W-1],
                ptr_q[fspc_pkg::MOD_W-1:0] - 21'h1}; // R15
            fspc_pkg::FSPC_PTR_PRE_INC: ptr_next = ptr_eff;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ptr_q <= 22'h0;
        end else if (ptr_we) begin
            ptr_q <= ptr_wdata;
        end else if ((table_op.fetch || table_op.load) && !stall_q) begin
            ptr_q <= ptr_next; // R2
        end
    end

    // read: address word in cycle 0, latch the selected byte in cycle 1
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mem_raddr <= 21'h0;
            fetch_pend_q <= 1'b0;
            fetch_lo_q <= 1'b0;
        end else begin
            fetch_pend_q <= table_op.fetch && !stall_q;
            if (table_op.fetch && !stall_q) begin
                mem_raddr <= ptr_eff[fspc_pkg::PTR_W-1:1];
                fetch_lo_q <= !ptr_eff[0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            latch_q <= 8'h0;
        end else if (fetch_pend_q) begin
            latch_q <= fetch_lo_q ? mem_rdata[7:0] : mem_rdata[15:8]; // R1 R3
        end else if (latch_we) begin
            latch_q <= latch_wdata;
        end
    end

    // holding registers, short writes only
    genvar gi;
    generate
        for (gi = 0; gi < fspc_pkg::HOLD_N; gi++) begin : g_hold
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    hold_q[gi] <= fspc_pkg::HOLD_RST;
                end else if (table_op.load && !stall_q && ptr_eff[2:0] == 3'(gi)) begin
                    hold_q[gi] <= latch_q; // R12 R13 R16
                end
            end
        end
    endgenerate

    // unlock sequence tracker; start, control, pointer or latch writes and table ops break it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            unl_q <= FSPC_UNL_NONE;
        end else if (unlock_we) begin
            if (unlock_wdata == fspc_pkg::UNLOCK_A) begin
                unl_q <= FSPC_UNL_HALF;
            end else if (unlock_wdata == fspc_pkg::UNLOCK_B && unl_q == FSPC_UNL_HALF) begin
                unl_q <= FSPC_UNL_FULL; // R8
            end else begin
                unl_q <= FSPC_UNL_NONE;
            end
        end else if (start_set || ctrl_we || table_op.fetch || table_op.load
                     || ptr_we || latch_we) begin
            unl_q <= FSPC_UNL_NONE; // R19
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_q <= '0;
        end else if (timer_done && erase_q) begin
            ctrl_q.row_erase <= 1'b0;
        end else if (ctrl_we && !start_q) begin
            ctrl_q <= ctrl_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            start_q <= 1'b0;
            erase_q <= 1'b0;
        end else if (accept) begin
            start_q <= 1'b1; // R17
            erase_q <= ctrl_q.row_erase;
        end else if (timer_done) begin
            start_q <= 1'b0; // R17
        end
    end

    // long write: array updates while the self timer counts, cpu held throughout
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= FSPC_IDLE;
            word_idx_q <= 5'h0;
            base_q <= 21'h0;
            wport_q <= '0;
        end else begin
            wport_q.we <= 1'b0;
            unique case (state_q)
                FSPC_IDLE: begin
                    if (accept) begin
                        word_idx_q <= 5'h0;
                        state_q <= FSPC_ARRAY; // R9 R20
                        if (ctrl_q.row_erase) begin
                            base_q <= {ptr_q[fspc_pkg::PTR_W-1:fspc_pkg::ERASE_LSB], 5'h0}; // R5
                        end else begin
                            base_q <= {ptr_q[fspc_pkg::PTR_W-1:fspc_pkg::BLOCK_LSB], 2'h0}; // R16
                        end
                    end
                end
                FSPC_ARRAY: begin
                    wport_q.we <= 1'b1;
                    wport_q.addr <= base_q | {16'h0, word_idx_q};
                    if (erase_q) begin
                        wport_q.data <= fspc_pkg::ERASED_WORD; // R4
                    end else begin
                        wport_q.data <= {hold_q[{word_idx_q[1:0], 1'b1}],
                                         hold_q[{word_idx_q[1:0], 1'b0}]}; // R11 R20
                    end
                    word_idx_q <= word_idx_q + 5'h1;
                    if ((erase_q && word_idx_q == 5'(fspc_pkg::ROW_WORDS - 1))
                        || (!erase_q && word_idx_q == 5'(fspc_pkg::BLK_WORDS - 1))) begin
                        state_q <= FSPC_WAIT; // R4 R11
                    end
                end
                FSPC_WAIT: begin
                    if (timer_done) begin
                        state_q <= FSPC_IDLE;
                    end
                end
                default: state_q <= FSPC_IDLE;
            endcase
        end
    end

    assign timer_start = accept;

    fspc_long_timer #(
        .CYCLES(LONG_WRITE_CYCLES)
    ) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .start(timer_start),
        .busy(timer_busy),
        .done(timer_done)
    );

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stall_q <= 1'b0;
        end else begin
            stall_q <= accept || (timer_busy && !timer_done); // R10
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            done_flag_q <= 1'b0;
        end else if (timer_done) begin
            done_flag_q <= 1'b1; // R18
        end else if (done_flag_clr) begin
            done_flag_q <= 1'b0;
        end
    end

    assign table_pointer = ptr_q;
    assign table_latch = latch_q;
    assign nvm_control = ctrl_q;
    assign start_busy = start_q;
    assign cpu_stall = stall_q;
    assign nvm_cycle_done_flag = done_flag_q;
    assign mem_wport = wport_q;
endmodule : fspc_ctrl

// *** dv/fspc_ctrl_monitor.sv ***
`timescale 1ns/1ps
module fspc_ctrl_monitor #(
    parameter int unsigned LONG_WRITE_CYCLES = 50
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire fspc_pkg::fspc_table_op_t table_op,
    input wire logic ptr_we,
    input wire logic start_set,
    input wire logic [7:0] unlock_wdata,
    input wire logic unlock_we,
    input wire logic done_flag_clr,
    input wire logic [fspc_pkg::WORD_AW-1:0] mem_raddr,
    input wire fspc_pkg::fspc_wport_t mem_wport,
    input wire logic [fspc_pkg::PTR_W-1:0] table_pointer,
    input wire fspc_pkg::fspc_ctrl_t nvm_control,
    input wire logic start_busy,
    input wire logic cpu_stall,
    input wire logic nvm_cycle_done_flag
);
    logic [31:0] busy_q;
    wire logic idle = !table_op.fetch && !table_op.load && !ptr_we;
    // length of the current busy run
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            busy_q <= '0;
        end else begin
            busy_q <= start_busy ? busy_q + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_unlock;
        (unlock_we && unlock_wdata == 8'h55) ##1 (unlock_we && unlock_wdata == 8'haa)
        ##1 (start_set && nvm_control.cycle_permit && !start_busy) |=> start_busy;
    endproperty
    a_unlock: assert property (p_unlock) else $error("start not taken");
    property p_permit;
        start_set && !nvm_control.cycle_permit && !start_busy |=> !start_busy;
    endproperty
    a_permit: assert property (p_permit) else $error("start without permit");
    property p_stall;
        start_busy |-> cpu_stall;
    endproperty
    a_stall: assert property (p_stall) else $error("busy without stall");
    property p_len;
        $fell(start_busy) |-> busy_q == LONG_WRITE_CYCLES + 1 && !cpu_stall;
    endproperty
    a_len: assert property (p_len) else $error("long write length");
    property p_flag_set;
        $fell(start_busy) |-> nvm_cycle_done_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("done flag not set");
    property p_flag_hold;
        nvm_cycle_done_flag && !done_flag_clr |=> nvm_cycle_done_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("done flag lost");
    property p_ptr_inc;
        table_op.fetch && table_op.mode == fspc_pkg::FSPC_PTR_POST_INC && !cpu_stall
        && !ptr_we ##1 idle |=> table_pointer[20:0] == $past(table_pointer[20:0], 2) + 21'h1
        && table_pointer[21] == $past(table_pointer[21], 2);
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer increment");
    property p_raddr;
        table_op.fetch && table_op.mode == fspc_pkg::FSPC_PTR_KEEP && !cpu_stall && !ptr_we
        ##1 idle |=> mem_raddr == $past(table_pointer[21:1], 2);
    endproperty
    a_raddr: assert property (p_raddr) else $error("read word address");
    property p_erase;
        mem_wport.we && nvm_control.row_erase |-> mem_wport.data == 16'hffff
        && mem_wport.addr[20:5] == table_pointer[21:6];
    endproperty
    a_erase: assert property (p_erase) else $error("erase write");
    property p_prog;
        mem_wport.we && !nvm_control.row_erase |-> mem_wport.addr[20:2] == table_pointer[21:3];
    endproperty
    a_prog: assert property (p_prog) else $error("program address");
    c_erase: cover property (mem_wport.we && nvm_control.row_erase);
    c_prog: cover property (mem_wport.we && !nvm_control.row_erase);
    c_done: cover property ($fell(start_busy));
endmodule : fspc_ctrl_monitor

bind fspc_ctrl fspc_ctrl_monitor #(.LONG_WRITE_CYCLES(LONG_WRITE_CYCLES)) i_mon (
    .clk(clk), .rst_b(rst_b), .table_op(table_op), .ptr_we(ptr_we), .start_set(start_set),
    .unlock_wdata(unlock_wdata), .unlock_we(unlock_we), .done_flag_clr(done_flag_clr),
    .mem_raddr(mem_raddr), .mem_wport(mem_wport), .table_pointer(table_pointer),
    .nvm_control(nvm_control), .start_busy(start_busy), .cpu_stall(cpu_stall),
    .nvm_cycle_done_flag(nvm_cycle_done_flag));

// *** dv/fspc_flash_model.sv ***
`timescale 1ns/1ps
module fspc_flash_model (
    input wire logic clk,
    input wire logic [20:0] raddr,
    input wire fspc_pkg::fspc_wport_t wport,
    output logic [15:0] rdata
);
    logic [15:0] mem [int unsigned];
    int unsigned wr_cnt = 0;
    // unwritten words read as an address pattern
    always_comb begin
        rdata = mem.exists(raddr) ? mem[raddr] : {raddr[7:0], ~raddr[7:0]};
    end
    always @(posedge clk) begin
        if (wport.we) begin
            mem[wport.addr] = wport.data;
            wr_cnt++;
        end
    end
endmodule : fspc_flash_model

// *** dv/flash_self_program_ctrl_bench.sv ***
`timescale 1ns/1ps
module flash_self_program_ctrl_bench;
    localparam int unsigned LWC = 50;
    logic clk = 0, rst_b = 0, latch_we = 0, ptr_we = 0, ctrl_we = 0, start_set = 0;
    logic unlock_we = 0, done_flag_clr = 0, start_busy, cpu_stall, nvm_cycle_done_flag;
    logic [7:0] latch_wdata = 0, unlock_wdata = 0, table_latch;
    logic [21:0] ptr_wdata = 0, table_pointer;
    logic [20:0] mem_raddr;
    logic [15:0] mem_rdata;
    fspc_pkg::fspc_table_op_t table_op = '0;
    fspc_pkg::fspc_ctrl_t ctrl_wdata = '0, nvm_control;
    fspc_pkg::fspc_wport_t mem_wport;
    int unsigned mismatches = 0, samples_checked = 0, cyc = 0, w0;
    always #4 clk = ~clk;
    fspc_ctrl #(.LONG_WRITE_CYCLES(LWC)) i_dut (.clk(clk), .rst_b(rst_b),
        .table_op(table_op), .latch_wdata(latch_wdata), .latch_we(latch_we),
        .ptr_wdata(ptr_wdata), .ptr_we(ptr_we), .ctrl_wdata(ctrl_wdata), .ctrl_we(ctrl_we),
        .start_set(start_set), .unlock_wdata(unlock_wdata), .unlock_we(unlock_we),
        .done_flag_clr(done_flag_clr), .mem_rdata(mem_rdata), .mem_raddr(mem_raddr),
        .mem_wport(mem_wport), .table_pointer(table_pointer), .table_latch(table_latch),
        .nvm_control(nvm_control), .start_busy(start_busy), .cpu_stall(cpu_stall),
        .nvm_cycle_done_flag(nvm_cycle_done_flag));
    fspc_flash_model i_mem (.clk(clk), .raddr(mem_raddr), .wport(mem_wport),
        .rdata(mem_rdata));
    task wrap_up;
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    task chk(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task tick;
        @(negedge clk);
    endtask : tick
    task op(logic f, fspc_pkg::fspc_ptr_mode_t m);
        table_op = '{f, !f, m};
        tick;
        table_op = '0;
    endtask : op
    task ld(logic [21:0] p);
        ptr_wdata = p;
        ptr_we = 1;
        tick;
        ptr_we = 0;
    endtask : ld
    task rd(fspc_pkg::fspc_ptr_mode_t m, logic [21:0] ep, logic [7:0] el);
        op(1, m);
        tick;
        tick;
        chk(table_pointer, ep);
        chk(table_latch, el);
    endtask : rd
    task launch(fspc_pkg::fspc_ctrl_t c, logic brk);
        ctrl_wdata = c;
        ctrl_we = 1;
        tick;
        ctrl_we = 0;
        unlock_wdata = 8'h55;
        unlock_we = 1;
        tick;
        if (brk) begin
            unlock_we = 0;
            latch_we = 1;
            tick;
            latch_we = 0;
            unlock_we = 1;
        end
        unlock_wdata = 8'haa;
        tick;
        unlock_we = 0;
        start_set = 1;
        tick;
        start_set = 0;
    endtask : launch
    task fin(int unsigned n);
        int unsigned c;
        c = 0;
        while (start_busy === 1'b1 && c < 200) begin
            tick;
            c++;
        end
        chk(c, n);
        chk(cpu_stall, 0);
        chk(nvm_cycle_done_flag, 1);
    endtask : fin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            wrap_up;
        end
    end
    initial begin
        repeat (2) tick;
        rst_b = 1;
        chk({table_pointer, start_busy, nvm_control}, 0);
        ld(22'h000101);
        rd(fspc_pkg::FSPC_PTR_KEEP, 22'h000101, 8'h80);
        rd(fspc_pkg::FSPC_PTR_POST_INC, 22'h000102, 8'h80);
        rd(fspc_pkg::FSPC_PTR_POST_INC, 22'h000103, 8'h7e);
        rd(fspc_pkg::FSPC_PTR_POST_DEC, 22'h000102, 8'h81);
        rd(fspc_pkg::FSPC_PTR_PRE_INC, 22'h000103, 8'h81);
        ld(22'h3fffff);
        rd(fspc_pkg::FSPC_PTR_POST_INC, 22'h200000, 8'hff);
        launch('{1, 0, 1, 0}, 0);
        tick;
        chk(start_busy, 0);
        launch('{1, 0, 1, 1}, 1);
        tick;
        chk(start_busy, 0);
        ld(22'h0003ff);
        for (int i = 0; i < 8; i++) begin
            latch_wdata = 8'h10 + 8'(i);
            latch_we = 1;
            tick;
            latch_we = 0;
            op(0, fspc_pkg::FSPC_PTR_PRE_INC);
        end
        w0 = i_mem.wr_cnt;
        launch('{1, 0, 0, 1}, 0);
        tick;
        chk(cpu_stall, 1);
        fin(LWC);
        chk(i_mem.wr_cnt - w0, 4);
        chk(i_mem.mem[32'h200], 16'h1110);
        chk(i_mem.mem[32'h203], 16'h1716);
        done_flag_clr = 1;
        tick;
        done_flag_clr = 0;
        chk(nvm_cycle_done_flag, 0);
        ld(22'h000401);
        rd(fspc_pkg::FSPC_PTR_KEEP, 22'h000401, 8'h11);
        ld(22'h000455);
        w0 = i_mem.wr_cnt;
        launch('{1, 0, 1, 1}, 0);
        op(1, fspc_pkg::FSPC_PTR_POST_INC);
        tick;
        chk(table_pointer, 22'h000455);
        fin(LWC - 1);
        chk(i_mem.wr_cnt - w0, 32);
        chk(i_mem.mem[32'h220], 16'hffff);
        chk(i_mem.mem[32'h23f], 16'hffff);
        chk(i_mem.mem.exists(32'h240), 0);
        chk(i_mem.mem[32'h200], 16'h1110);
        chk(nvm_control.row_erase, 0);
        wrap_up;
    end
endmodule : flash_self_program_ctrl_bench
